// ---- est_defines.svh ----
// offsets, field positions, reset values and timing counts of the transmitter
`ifndef EST_DEFINES_SVH
`define EST_DEFINES_SVH

`define EST_OFF_TXSC      8'h00
`define EST_OFF_RXSC      8'h04
`define EST_OFF_BAUDC     8'h08
`define EST_OFF_DIVL      8'h0c
`define EST_OFF_DIVH      8'h10
`define EST_OFF_HOLD      8'h14
`define EST_OFF_IRQ       8'h18

`define EST_TXSC_NINE     6
`define EST_TXSC_TRANSMIT_ENABLE     5
`define EST_TXSC_CLKMODE  4
`define EST_TXSC_HSPEED   2
`define EST_TXSC_SREMPTY  1
`define EST_TXSC_NINTHBIT 0
`define EST_RXSC_SERIAL_PORT_ENABLE     7
`define EST_BAUDC_WIDE    3
`define EST_IRQ_FLAG      0
`define EST_IRQ_TX_BUFFER_EMPTY_IRQ_ENABLE      1
`define EST_IRQ_PERIPHERAL_IRQ_ENABLE      2
`define EST_IRQ_GIE       3

`define EST_TXSC_RST      8'h00
`define EST_RXSC_RST      8'h00
`define EST_BAUDC_RST     8'h00
`define EST_DIV_RST       8'h00
`define EST_IRQ_RST       3'h0

`define EST_PRE_SLOW      6'd63
`define EST_PRE_MID       6'd15
`define EST_PRE_FAST      6'd3
`define EST_BITS8_LAST    4'd7
`define EST_BITS9_LAST    4'd8

`endif

// ---- est_pkg.sv ----
// types shared by the serial transmitter
package est_pkg;

  typedef enum logic [1:0] {
    EST_IDLE  = 2'b00,
    EST_START = 2'b01,
    EST_DATA  = 2'b10,
    EST_STOP  = 2'b11
  } est_state_t;

  typedef enum logic [2:0] {
    EST_R_TXSC  = 3'd0,
    EST_R_RXSC  = 3'd1,
    EST_R_BAUDC = 3'd2,
    EST_R_DIVL  = 3'd3,
    EST_R_DIVH  = 3'd4,
    EST_R_HOLD  = 3'd5,
    EST_R_IRQ   = 3'd6,
    EST_R_NONE  = 3'd7
  } est_reg_t;

endpackage : est_pkg

// ---- est_tx.sv ----
// asynchronous serial transmitter with apb registers
`timescale 1ns/10ps
`include "est_defines.svh"

module est_tx (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_pin_in,
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  output logic             gpio_in,
  output logic             tx_irq_req
);
  import est_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  function automatic est_pkg::est_reg_t reg_sel(input logic [7:0] a);
    if (a == `EST_OFF_TXSC) begin
      return EST_R_TXSC;
    end else if (a == `EST_OFF_RXSC) begin
      return EST_R_RXSC;
    end else if (a == `EST_OFF_BAUDC) begin
      return EST_R_BAUDC;
    end else if (a == `EST_OFF_DIVL) begin
      return EST_R_DIVL;
    end else if (a == `EST_OFF_DIVH) begin
      return EST_R_DIVH;
    end else if (a == `EST_OFF_HOLD) begin
      return EST_R_HOLD;
    end else if (a == `EST_OFF_IRQ) begin
      return EST_R_IRQ;
    end else begin
      return EST_R_NONE;
    end
  endfunction : reg_sel

  logic [7:0]  txsc_q;
  logic [7:0]  rxsc_q;
  logic [7:0]  baudc_q;
  logic [7:0]  divl_q;
  logic [7:0]  divh_q;
  logic [8:0]  hold_q;
  logic        hold_full_q;
  logic [2:0]  irqen_q;
  logic        flag_q;
  logic        irq_q;
  est_state_t  state_q;
  logic [8:0]  shift_q;
  logic [3:0]  bitcnt_q;
  logic [5:0]  pre_q;
  logic [15:0] brg_q;
  logic        pin_out_q;
  logic        pin_oe_q;
  logic        sync1_q;
  logic        sync2_q;
  logic [31:0] rdata_q;

  est_reg_t    sel;
  logic        wr_en;
  logic        serial_port_enable;
  logic        transmit_enable;
  logic        active;
  logic        nine;
  logic        sr_empty;
  logic        load;
  logic        bit_tick;
  logic        tx_line;
  logic [5:0]  pre_len;
  logic [15:0] div_val;

  assign sel      = reg_sel(paddr);
  assign wr_en    = psel & penable & pwrite;
  assign serial_port_enable     = rxsc_q[`EST_RXSC_SERIAL_PORT_ENABLE];
  assign transmit_enable     = txsc_q[`EST_TXSC_TRANSMIT_ENABLE];
  assign active   = transmit_enable & serial_port_enable & ~txsc_q[`EST_TXSC_CLKMODE];
  assign nine     = txsc_q[`EST_TXSC_NINE];
  assign sr_empty = (state_q == EST_IDLE);
  assign load     = active & hold_full_q & sr_empty;

  ////////////////////////////////////////////////////////////////////////
  // zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel == EST_R_NONE);
  assign prdata  = rdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txsc_q  <= `EST_TXSC_RST;
      rxsc_q  <= `EST_RXSC_RST;
      baudc_q <= `EST_BAUDC_RST;
      divl_q  <= `EST_DIV_RST;
      divh_q  <= `EST_DIV_RST;
      irqen_q <= `EST_IRQ_RST;
    end else if (wr_en) begin
      if (sel == EST_R_TXSC) begin
        txsc_q <= pwdata[7:0];
      end else if (sel == EST_R_RXSC) begin
        rxsc_q <= pwdata[7:0];
      end else if (sel == EST_R_BAUDC) begin
        baudc_q <= pwdata[7:0];
      end else if (sel == EST_R_DIVL) begin
        divl_q <= pwdata[7:0];
      end else if (sel == EST_R_DIVH) begin
        divh_q <= pwdata[7:0];
      end else if (sel == EST_R_IRQ) begin
        irqen_q <= pwdata[`EST_IRQ_GIE:`EST_IRQ_TX_BUFFER_EMPTY_IRQ_ENABLE];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      rdata_q <= 32'h0000_0000;
      if (sel == EST_R_TXSC) begin
        rdata_q[7:0] <= txsc_q;
        rdata_q[`EST_TXSC_SREMPTY] <= sr_empty;
      end else if (sel == EST_R_RXSC) begin
        rdata_q[7:0] <= rxsc_q;
      end else if (sel == EST_R_BAUDC) begin
        rdata_q[7:0] <= baudc_q;
      end else if (sel == EST_R_DIVL) begin
        rdata_q[7:0] <= divl_q;
      end else if (sel == EST_R_DIVH) begin
        rdata_q[7:0] <= divh_q;
      end else if (sel == EST_R_IRQ) begin
        rdata_q[`EST_IRQ_GIE:`EST_IRQ_TX_BUFFER_EMPTY_IRQ_ENABLE] <= irqen_q;
        rdata_q[`EST_IRQ_FLAG] <= flag_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end else if (!serial_port_enable) begin
      hold_full_q <= 1'b0;
    end else if (wr_en && sel == EST_R_HOLD) begin
      hold_q      <= {txsc_q[`EST_TXSC_NINTHBIT], pwdata[7:0]};
      hold_full_q <= 1'b1;
    end else if (load) begin
      hold_full_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= transmit_enable & ~hold_full_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q & (&irqen_q);
    end
  end
  assign tx_irq_req = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // prescale and divisor
  always_comb begin
    pre_len = `EST_PRE_MID;
    if (!baudc_q[`EST_BAUDC_WIDE] && !txsc_q[`EST_TXSC_HSPEED]) begin
      pre_len = `EST_PRE_SLOW;
    end else if (baudc_q[`EST_BAUDC_WIDE] && txsc_q[`EST_TXSC_HSPEED]) begin
      pre_len = `EST_PRE_FAST;
    end
  end
  assign div_val  = baudc_q[`EST_BAUDC_WIDE] ? {divh_q, divl_q} : {8'h00, divl_q};
  assign bit_tick = (pre_q == 6'd0) && (brg_q == 16'h0000) && !load;

  // restarting on load keeps the start bit a full period long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'd0;
      brg_q <= 16'h0000;
    end else if (load || sr_empty) begin
      pre_q <= pre_len;
      brg_q <= div_val;
    end else if (pre_q == 6'd0) begin
      pre_q <= pre_len;
      brg_q <= (brg_q == 16'h0000) ? div_val : brg_q - 16'h0001;
    end else begin
      pre_q <= pre_q - 6'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // no parity logic here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= EST_IDLE;
      shift_q  <= 9'h1ff;
      bitcnt_q <= 4'd0;
    end else if (!active) begin
      state_q <= EST_IDLE;
    end else begin
      case (state_q)
        EST_IDLE: begin
          if (load) begin
            state_q  <= EST_START;
            shift_q  <= hold_q;
            bitcnt_q <= nine ? `EST_BITS9_LAST : `EST_BITS8_LAST;
          end
        end
        EST_START: begin
          if (bit_tick) begin
            state_q <= EST_DATA;
          end
        end
        EST_DATA: begin
          if (bit_tick) begin
            shift_q <= {1'b1, shift_q[8:1]};
            if (bitcnt_q == 4'd0) begin
              state_q <= EST_STOP;
            end else begin
              bitcnt_q <= bitcnt_q - 4'd1;
            end
          end
        end
        EST_STOP: begin
          if (bit_tick) begin
            state_q <= EST_IDLE;
          end
        end
        default: begin
          state_q <= EST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    tx_line = 1'b1;
    if (state_q == EST_START) begin
      tx_line = 1'b0;
    end else if (state_q == EST_DATA) begin
      tx_line = shift_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port enable drives pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b1;
      pin_oe_q  <= 1'b0;
    end else begin
      pin_out_q <= (serial_port_enable & transmit_enable) ? tx_line : gpio_out;
      pin_oe_q  <= serial_port_enable | gpio_oe;
    end
  end
  assign tx_pin_out = pin_out_q;
  assign tx_pin_oe  = pin_oe_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= tx_pin_in;
      sync2_q <= sync1_q;
    end
  end
  assign gpio_in = sync2_q;

  ////////////////////////////////////////////////////////////////////////
  property p_idle_mark;
    @(posedge pclk) disable iff (!presetn)
      (state_q == EST_IDLE) |-> tx_line;
  endproperty
  a_idle_mark: assert property (p_idle_mark)
    else $error("line not at mark while idle");

  property p_start_space;
    @(posedge pclk) disable iff (!presetn)
      (state_q == EST_IDLE && load) |=> (state_q == EST_START) && !tx_line;
  endproperty
  a_start_space: assert property (p_start_space)
    else $error("start bit missing after load");

  property p_bit_hold;
    @(posedge pclk) disable iff (!presetn)
      (active && !sr_empty && !bit_tick) |=> $stable(tx_line);
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("line changed inside a bit period");

  property p_lsb_first;
    @(posedge pclk) disable iff (!presetn)
      (active && state_q == EST_DATA && bit_tick && bitcnt_q != 4'd0)
        |=> tx_line == $past(shift_q[1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("data bit order wrong");

  property p_load_now;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && sel == EST_R_HOLD && active && sr_empty)
        |=> ##1 (state_q == EST_START);
  endproperty
  a_load_now: assert property (p_load_now)
    else $error("idle shifter did not load written char");

  property p_stop_reload;
    @(posedge pclk) disable iff (!presetn)
      (active && state_q == EST_STOP && bit_tick && hold_full_q)
        |=> (state_q == EST_IDLE) ##1 (state_q == EST_START);
  endproperty
  a_stop_reload: assert property (p_stop_reload)
    else $error("pending char not loaded after stop");

  property p_flag_empty;
    @(posedge pclk) disable iff (!presetn)
      (transmit_enable && !hold_full_q) ##1 (transmit_enable && !hold_full_q) |-> flag_q;
  endproperty
  a_flag_empty: assert property (p_flag_empty)
    else $error("empty flag low with empty buffer");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      tx_irq_req |-> $past(flag_q) && $past(irqen_q) == 3'h7;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without all enables");

  property p_one_stop;
    @(posedge pclk) disable iff (!presetn)
      (active && state_q == EST_STOP && bit_tick) |=> sr_empty;
  endproperty
  a_one_stop: assert property (p_one_stop)
    else $error("more than one stop bit");

endmodule : est_tx

// ---- est_rx_model.sv ----
// remote serial receiver model watching the transmit line
`timescale 1ns/10ps

module est_rx_model #(
  parameter int BIT = 12
) (
  input  wire logic  pclk,
  input  wire logic  line,
  input  wire logic  nine,
  output logic [8:0] rx_data,
  output int         rx_count,
  output int         rx_gap
);
  int cyc;
  int last;
  int i;

  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rx_count = 0;
    rx_gap   = 0;
    rx_data  = '0;
    last     = 0;
    forever begin
      @(negedge line);
      rx_gap = cyc - last;
      last   = cyc;
      repeat (BIT / 2) @(posedge pclk);
      if (line === 1'b0) begin
        // lsb first, ninth last marks address
        for (i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT) @(posedge pclk);
          rx_data[i] = line;
        end
        if (!nine) rx_data[8] = 1'b0;
        repeat (BIT) @(posedge pclk);
        // stop at mark, bad frames dropped
        if (line === 1'b1) rx_count++;
      end
    end
  end
endmodule : est_rx_model

// ---- test_async_serial_transmitter.sv ----
// self-checking testbench of the serial transmitter
`timescale 1ns/10ps
`include "est_defines.svh"

module test_async_serial_transmitter;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e, tx_pin_out, tx_pin_oe, gpio_out, gpio_oe, gpio_in, tx_irq_req;
  logic        pin_lvl, nine_mode;
  logic [8:0]  rx_data;
  int          rx_count, rx_gap, n_fail, n_checks;

  // pull-up holds the pin at mark when nobody drives
  assign pin_lvl = tx_pin_oe ? tx_pin_out : 1'b1;

  est_tx u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_pin_in(pin_lvl), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .tx_irq_req(tx_irq_req)
  );

  // bit period: fast prescale 4 times divisor 2 plus one
  est_rx_model #(.BIT(12)) u_rx (
    .pclk(pclk), .line(pin_lvl), .nine(nine_mode),
    .rx_data(rx_data), .rx_count(rx_count), .rx_gap(rx_gap)
  );

  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, exp, r);
  endtask : rdchk

  task automatic wait_rx(input int n);
    int w;
    w = 0;
    while (rx_count < n && w < 5000) begin
      @(posedge pclk);
      w++;
    end
    if (rx_count < n) n_fail++;
  endtask : wait_rx

  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, gpio_oe, nine_mode} = '0;
    paddr = '0;
    pwdata = '0;
    gpio_out = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`EST_OFF_TXSC, 32'h02, "txsc reset");
    chk("idle line", 32'h1, {31'h0, pin_lvl});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    apb(1'b1, `EST_OFF_BAUDC, 32'h08);
    apb(1'b1, `EST_OFF_DIVL, 32'h02);
    apb(1'b1, `EST_OFF_RXSC, 32'h80);
    apb(1'b1, `EST_OFF_TXSC, 32'h24);
    chk("pin drive", 32'h1, {31'h0, tx_pin_oe});
    // flag bit written 0 must not clear it
    apb(1'b1, `EST_OFF_IRQ, 32'h0e);
    rdchk(`EST_OFF_IRQ, 32'h0f, "flag on enable");
    chk("irq raised", 32'h1, {31'h0, tx_irq_req});
    apb(1'b1, `EST_OFF_HOLD, 32'ha5);
    apb(1'b1, `EST_OFF_HOLD, 32'h3c);
    rdchk(`EST_OFF_IRQ, 32'h0e, "flag full");
    chk("irq low", 32'h0, {31'h0, tx_irq_req});
    rdchk(`EST_OFF_TXSC, 32'h24, "shifter busy");
    wait_rx(1);
    chk("char 1", 32'ha5, {23'h0, rx_data});
    wait_rx(2);
    chk("char 2", 32'h3c, {23'h0, rx_data});
    // one stop bit and the load cycle give 121 cycles; the pin register delays both edges alike
    chk("gap", 32'h1, {31'h0, rx_gap >= 120 && rx_gap <= 122});
    repeat (20) @(posedge pclk);
    rdchk(`EST_OFF_TXSC, 32'h26, "shifter empty");
    apb(1'b1, `EST_OFF_IRQ, 32'h0a);
    rdchk(`EST_OFF_IRQ, 32'h0b, "flag ungated");
    chk("irq gated", 32'h0, {31'h0, tx_irq_req});
    nine_mode <= 1'b1;
    apb(1'b1, `EST_OFF_TXSC, 32'h65);
    apb(1'b1, `EST_OFF_HOLD, 32'h55);
    apb(1'b1, `EST_OFF_IRQ, 32'h08);
    wait_rx(3);
    chk("nine bit", 32'h155, {23'h0, rx_data});
    apb(1'b1, `EST_OFF_TXSC, 32'h34);
    apb(1'b1, `EST_OFF_HOLD, 32'h00);
    repeat (40) @(posedge pclk);
    chk("clocked mode", 32'h3, rx_count);
    chk("line mark", 32'h1, {31'h0, pin_lvl});
    apb(1'b1, `EST_OFF_TXSC, 32'h04);
    rdchk(`EST_OFF_IRQ, 32'h08, "flag off");
    apb(1'b1, `EST_OFF_RXSC, 32'h00);
    gpio_oe  <= 1'b1;
    gpio_out <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("gpio pin", 32'h0, {31'h0, gpio_in});
    tally_and_finish();
  end
endmodule : test_async_serial_transmitter
